// ==== esm_mcu_model.sv ====
// Behavioural model of the microcontroller driving the error input
module esm_mcu_model #(
  parameter int TICK_CYC = 4
) (
  // Clock
  input  wire logic clk,
  // Error signalling line towards the monitor
  output logic      err_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line idles high until the first phase is driven
  initial err_line = 1'b1;

  // Drive one phase of a level for a whole number of ticks
  task automatic hold(input logic lvl, input int ticks);
    @(posedge clk);
    err_line <= lvl;
    repeat (ticks * TICK_CYC - 1) @(posedge clk);
  endtask

  // One correct pattern: two in-window phases of opposite level
  task automatic good_pair(input logic first, input int ticks);
    hold(first, ticks);
    hold(!first, ticks);
  endtask
endmodule

// ==== esm_monitor.sv ====
// Error signal monitor with failure counter and AHB-Lite registers
//
// Overview of operation
// - Two modes, low pulse or PWM, picked by one mode select bit.
// - Monitor idle after reset; runs only once enable bit is written 1.
// - Low pulse mode checks each low phase against the low maximum.
// - Low pulse mode, input high at enable: checking starts at first fall.
// - Low at enable and no rise in startup window: error, count, restart.
// - Startup window equals low maximum plus high maximum.
// - PWM mode uses low min, low max, high min and high max limits.
// - PWM mode starts checking at the first edge after enable.
// - PWM mode, no edge within low max plus high max: error, count up.
// - PWM phase over its max, or shorter than the min of the level after it: error, count up, fresh cycle.
// - Correct PWM pattern is a good low then good high, or reverse.
// - Failure counter counts down on each correct pattern.
// - A new monitoring event starts after every error or good pattern.
// - ACTIVE, count above driver threshold, no reset option: safe, drive low.
// - DIAG or ACTIVE, count above reset threshold, reset option: reset.
// - DIAG or ACTIVE, count above reset threshold, no reset option: safe.
// - Already in SAFE with reset threshold not above driver one: no action.
// - Reset, RESET entry, self test end, mode toggle, disable: reinit.
// - Counter back to default on SAFE to DIAG and enable rising too.
module esm_monitor #(
  parameter int TICK_CYC = esm_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic      [1:0]  HRESP,
  // Monitored error input
  input  wire logic        ERR_IN,
  // Device context
  input  wire logic [1:0]  DEV_STATE,
  input  wire logic        LOGIC_SELF_TEST_DONE,
  input  wire logic        ENDRV_ACT,
  // Results
  output logic             ENABLE_OR_INTERRUPT_OUTPUT,
  output logic             REQ_SAFE,
  output logic             REQ_RESET
);

  // Control and configuration
  logic             en_ff;
  logic             mode_ff;
  logic             rsten_ff;
  esm_pkg::esm_lim_t lim_ff;
  logic [3:0]       endrv_th_ff;
  logic [3:0]       rst_th_ff;
  // Status
  logic [3:0]       fc_ff;
  logic             fail_ff;
  logic             rfail_ff;
  // Monitor
  esm_pkg::esm_st_t st_ff;
  esm_pkg::esm_st_t nxt_st;
  logic [8:0]       cnt_ff;
  logic [8:0]       nxt_cnt;
  logic             half_ff;
  logic             nxt_half;
  logic             err;
  logic             good;
  // Bus
  logic             wr_ff;
  logic [7:0]       a_ff;
  logic [1:0]       dev_ff;
  // Outputs
  logic [31:0]      rdata_ff;
  logic             endrv_ff;
  logic             rsafe_ff;
  logic             rreset_ff;

  assign HRDATA                     = rdata_ff;
  assign HREADYOUT                  = 1'b1;
  assign HRESP                      = esm_pkg::HRESP_OKAY;
  assign ENABLE_OR_INTERRUPT_OUTPUT = endrv_ff;
  assign REQ_SAFE                   = rsafe_ff;
  assign REQ_RESET                  = rreset_ff;

  // Saturating counter step
  function automatic logic [3:0] fc_step(input logic [3:0] v,
                                         input logic up,
                                         input logic dn);
    logic [3:0] r;
    r = v;
    if (up && v != esm_pkg::FC_MAX)
      r = v + 4'h1;
    else if (dn && !up && v != 4'h0)
      r = v - 4'h1;
    return r;
  endfunction

  // Synchronised input and time base
  logic lvl;
  logic rise;
  logic fall;
  logic tick;
  logic edge_s;

  assign edge_s = rise | fall;

  esm_sync #(
    .TICK_CYC (TICK_CYC)
  ) u_sync (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .din      (ERR_IN),
    .tick_clr (edge_s),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall),
    .tick     (tick)
  );

  // Bus address phase decode
  wire       take    = HSEL & HREADY & (HTRANS == esm_pkg::HTRANS_NONSEQ);
  wire       wr_ctrl = wr_ff & (a_ff == esm_pkg::A_CTRL);
  wire       wr_lim  = wr_ff & (a_ff == esm_pkg::A_LIM);
  wire       wr_thr  = wr_ff & (a_ff == esm_pkg::A_THR);
  wire       wr_stat = wr_ff & (a_ff == esm_pkg::A_STAT);

  // Read mux, unmapped offsets read zero
  wire [31:0] ctrl_rd = {29'h0, rsten_ff, mode_ff, en_ff};
  wire [31:0] thr_rd  = {24'h0, rst_th_ff, endrv_th_ff};
  wire        running = (st_ff != esm_pkg::ST_IDLE);
  wire [31:0] stat_rd = {25'h0, running, rfail_ff, fail_ff, fc_ff};
  wire [31:0] rd_mux  =
    (HADDR == esm_pkg::A_CTRL) ? ctrl_rd :
    (HADDR == esm_pkg::A_LIM)  ? lim_ff  :
    (HADDR == esm_pkg::A_THR)  ? thr_rd  :
    (HADDR == esm_pkg::A_STAT) ? stat_rd : 32'h0;

  // Initialisation events
  wire rst_entry = (DEV_STATE == esm_pkg::DS_RESET) &&
                   (dev_ff != esm_pkg::DS_RESET);
  wire safe2diag = (dev_ff == esm_pkg::DS_SAFE) &&
                   (DEV_STATE == esm_pkg::DS_DIAG);
  wire mode_tog  = wr_ctrl & (HWDATA[esm_pkg::C_MODE] != mode_ff);
  wire en_clr    = wr_ctrl & en_ff & ~HWDATA[esm_pkg::C_EN];
  wire en_set    = wr_ctrl & ~en_ff & HWDATA[esm_pkg::C_EN];
  wire cyc_init  = rst_entry | LOGIC_SELF_TEST_DONE | mode_tog | en_clr;
  wire fc_init   = cyc_init | safe2diag | en_set;
  wire restart   = cyc_init | en_set;

  // Phase limits for the level being measured
  wire [8:0] to_lim = {1'b0, lim_ff.lmax} + {1'b0, lim_ff.hmax};
  wire [8:0] ph_max = {1'b0, lvl ? lim_ff.hmax : lim_ff.lmax};
  wire [8:0] ph_min = {1'b0, lvl ? lim_ff.hmin : lim_ff.lmin};
  wire [8:0] cnt_up = tick ? cnt_ff + 9'h001 : cnt_ff;

  // Threshold decisions
  wire in_act   = (DEV_STATE == esm_pkg::DS_ACTIVE);
  wire in_diag  = (DEV_STATE == esm_pkg::DS_DIAG);
  // Counter about to be reloaded: its old value must not trip
  wire over_drv = (fc_ff > endrv_th_ff) & ~fc_init;
  wire over_rst = (fc_ff > rst_th_ff) & ~fc_init;
  wire trip_drv = in_act & over_drv & ~rsten_ff;
  wire trip_rr  = (in_act | in_diag) & over_rst & rsten_ff;
  wire trip_rs  = (in_act | in_diag) & over_rst & ~rsten_ff;
  wire trip     = trip_drv | trip_rr | trip_rs;

  // Monitor sequencing
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_up;
    nxt_half = half_ff;
    err      = 1'b0;
    good     = 1'b0;
    unique case (st_ff)
      esm_pkg::ST_IDLE:
      begin
        nxt_cnt  = 9'h000;
        nxt_half = 1'b0;
        if (en_ff)
          nxt_st = (mode_ff || !lvl) ? esm_pkg::ST_START
                                     : esm_pkg::ST_ARM;
      end
      esm_pkg::ST_ARM:
      begin
        nxt_cnt = 9'h000;
        if (fall)
          nxt_st = esm_pkg::ST_PHASE;
      end
      esm_pkg::ST_START:
      begin
        if (mode_ff && edge_s)
        begin
          nxt_st   = esm_pkg::ST_PHASE;
          nxt_cnt  = 9'h000;
          nxt_half = 1'b0;
        end
        else if (!mode_ff && rise)
        begin
          nxt_st  = esm_pkg::ST_ARM;
          nxt_cnt = 9'h000;
        end
        else if (cnt_ff >= to_lim)
        begin
          err     = 1'b1;
          nxt_cnt = 9'h000;
        end
      end
      esm_pkg::ST_PHASE:
      begin
        if (cnt_ff > ph_max)
        begin
          err      = 1'b1;
          nxt_st   = esm_pkg::ST_START;
          nxt_cnt  = 9'h000;
          nxt_half = 1'b0;
        end
        else if (!mode_ff && rise)
        begin
          good    = 1'b1;
          nxt_st  = esm_pkg::ST_ARM;
          nxt_cnt = 9'h000;
        end
        else if (mode_ff && edge_s)
        begin
          nxt_cnt = 9'h000;
          if (cnt_ff < ph_min)
          begin
            err      = 1'b1;
            nxt_half = 1'b0;
          end
          else
          begin
            good     = half_ff;
            nxt_half = ~half_ff;
          end
        end
      end
    endcase
    if (restart || !en_ff)
    begin
      nxt_st   = esm_pkg::ST_IDLE;
      nxt_cnt  = 9'h000;
      nxt_half = 1'b0;
    end
  end

  // Bus phase capture and read data
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      wr_ff    <= 1'b0;
      a_ff     <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wr_ff    <= take & HWRITE;
      a_ff     <= HADDR;
      rdata_ff <= (take && !HWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software configuration registers
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      {rsten_ff, mode_ff, en_ff} <= esm_pkg::CTRL_RST;
      lim_ff                     <= esm_pkg::LIM_RST;
      {rst_th_ff, endrv_th_ff}   <= esm_pkg::THR_RST;
    end
    else
    begin
      if (wr_ctrl)
        {rsten_ff, mode_ff, en_ff} <= HWDATA[2:0];
      if (wr_lim)
        lim_ff <= HWDATA;
      if (wr_thr)
        {rst_th_ff, endrv_th_ff} <= HWDATA[7:0];
    end
  end

  // Monitor state and phase timer
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      st_ff   <= esm_pkg::ST_IDLE;
      cnt_ff  <= 9'h000;
      half_ff <= 1'b0;
      dev_ff  <= esm_pkg::DS_DIAG;
    end
    else
    begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      half_ff <= nxt_half;
      dev_ff  <= DEV_STATE;
    end
  end

  // Failure counter and sticky flags, set wins over clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      fc_ff    <= esm_pkg::THR_RST[3:0];
      fail_ff  <= 1'b0;
      rfail_ff <= 1'b0;
    end
    else
    begin
      if (fc_init)
        fc_ff <= endrv_th_ff;
      else
        fc_ff <= fc_step(fc_ff, err, good);
      if (cyc_init)
        fail_ff <= 1'b0;
      else if (trip)
        fail_ff <= 1'b1;
      else if (wr_stat && HWDATA[esm_pkg::S_FAIL])
        fail_ff <= 1'b0;
      if (trip)
        rfail_ff <= 1'b1;
      else if (wr_stat && HWDATA[esm_pkg::S_RFAIL])
        rfail_ff <= 1'b0;
    end
  end

  // State requests and enable driver
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      endrv_ff  <= 1'b0;
      rsafe_ff  <= 1'b0;
      rreset_ff <= 1'b0;
    end
    else
    begin
      endrv_ff  <= ENDRV_ACT & ~(in_act & over_drv & ~rsten_ff);
      rsafe_ff  <= trip_drv | trip_rs;
      rreset_ff <= trip_rr;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_arm_lp;
    st_ff == esm_pkg::ST_IDLE && en_ff && !restart && !mode_ff && lvl;
  endsequence

  sequence s_pwm_go;
    st_ff == esm_pkg::ST_START && mode_ff && edge_s && !restart && en_ff;
  endsequence

  chk_off_idle: assert property (
    !en_ff |=> st_ff == esm_pkg::ST_IDLE)
    else $error("monitor running while disabled");

  chk_lp_low_only: assert property (
    st_ff == esm_pkg::ST_PHASE && !mode_ff |-> !lvl || rise)
    else $error("low pulse mode measuring a high phase");

  chk_lp_arm: assert property (
    s_arm_lp |=> st_ff == esm_pkg::ST_ARM)
    else $error("low pulse mode did not wait for a fall");

  chk_to_sum: assert property (
    to_lim == 9'(lim_ff.lmax) + 9'(lim_ff.hmax))
    else $error("startup window not low max plus high max");

  chk_pwm_edge: assert property (
    s_pwm_go |=> st_ff == esm_pkg::ST_PHASE && cnt_ff == 9'h000)
    else $error("pwm mode did not start at an edge");

  chk_err_count: assert property (
    err && !fc_init && fc_ff != esm_pkg::FC_MAX
      |=> fc_ff == $past(fc_ff) + 4'h1)
    else $error("error did not raise the counter");

  chk_good_count: assert property (
    good && !err && !fc_init && fc_ff != 4'h0
      |=> fc_ff == $past(fc_ff) - 4'h1)
    else $error("good pattern did not lower the counter");

  chk_fc_sat: assert property (
    fc_ff == esm_pkg::FC_MAX && !fc_init |=> fc_ff != 4'h0)
    else $error("failure counter wrapped");

  chk_fc_init: assert property (
    fc_init |=> fc_ff == $past(endrv_th_ff))
    else $error("counter not restored to default");

  chk_req_reset: assert property (
    trip_rr |=> REQ_RESET && rfail_ff && (fail_ff || $past(cyc_init)))
    else $error("reset request or flags missing");

  chk_req_safe: assert property (
    trip_rs |=> REQ_SAFE && rfail_ff)
    else $error("safe request or flags missing");

  chk_drv_low: assert property (
    trip_drv |=> !ENABLE_OR_INTERRUPT_OUTPUT && REQ_SAFE)
    else $error("enable output not driven low");

  chk_safe_quiet: assert property (
    DEV_STATE == esm_pkg::DS_SAFE |=> !REQ_SAFE && !REQ_RESET)
    else $error("request raised in safe state");

  chk_new_event: assert property (
    err && st_ff == esm_pkg::ST_PHASE && !restart && en_ff
      |=> (st_ff == esm_pkg::ST_START || st_ff == esm_pkg::ST_PHASE) &&
          cnt_ff == 9'h000 && !half_ff)
    else $error("no fresh event after an error");

endmodule

// ==== esm_pkg.sv ====
// Shared constants and types for the error signal monitor
package esm_pkg;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LIM  = 8'h04;
  localparam logic [7:0] A_THR  = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;

  // Control field positions
  localparam int C_EN    = 0;
  localparam int C_MODE  = 1;
  localparam int C_RSTEN = 2;

  // Status field positions
  localparam int S_FAIL  = 4;
  localparam int S_RFAIL = 5;
  localparam int S_RUN   = 6;

  // Reset values
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [31:0] LIM_RST  = 32'h1002_1002;
  localparam logic [7:0]  THR_RST  = 8'hF5;

  // Device state codes on the state input
  localparam logic [1:0] DS_DIAG   = 2'h0;
  localparam logic [1:0] DS_ACTIVE = 2'h1;
  localparam logic [1:0] DS_SAFE   = 2'h2;
  localparam logic [1:0] DS_RESET  = 2'h3;

  // Bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  // Time base
  localparam int CLK_NS   = 8;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] FC_MAX = 4'hF;

  // Monitor states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ARM   = 4'h2,
    ST_START = 4'h4,
    ST_PHASE = 4'h8
  } esm_st_t;

  // Pulse width limits in time base ticks
  typedef struct packed {
    logic [7:0] hmax;
    logic [7:0] hmin;
    logic [7:0] lmax;
    logic [7:0] lmin;
  } esm_lim_t;

endpackage

// ==== esm_sync.sv ====
// Input synchroniser, edge detector and time base prescaler
module esm_sync #(
  parameter int TICK_CYC = esm_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Raw input and prescaler restart
  input  wire logic din,
  input  wire logic tick_clr,
  // Synchronised level, edges and tick
  output logic      level,
  output logic      rise,
  output logic      fall,
  output logic      tick
);
  localparam int PW = $clog2(TICK_CYC + 1);
  localparam logic [PW-1:0] P_LAST = PW'(TICK_CYC - 1);

  logic          s1_ff;
  logic          s2_ff;
  logic          s3_ff;
  logic [PW-1:0] pre_ff;

  // Edges seen from the second and third stages only
  assign level = s2_ff;
  assign rise  = s2_ff & ~s3_ff;
  assign fall  = ~s2_ff & s3_ff;
  assign tick  = (pre_ff == P_LAST);

  // Two stage synchroniser plus history stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Prescaler, realigned at every measured edge
  always_ff @(posedge clk)
  begin
    if (!rst_n || tick_clr || tick)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + PW'(1);
  end

endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the error signal monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int          TCYC  = 4;
  localparam int          LIMIT = 10000;
  localparam logic [31:0] M_ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] M_ST  = 32'h0000_003F;

  logic        clk_sys;
  logic        rst_n;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic        err_in;
  logic [1:0]  dev_state;
  logic        logic_self_test_done;
  logic        endrv_act;
  logic        eoi;
  logic        req_safe;
  logic        req_reset;
  int          err_total = 0;
  int          n_tests   = 0;
  int          cycles    = 0;

  esm_monitor #(.TICK_CYC(TCYC)) esm_monitor_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .ERR_IN(err_in), .DEV_STATE(dev_state),
    .LOGIC_SELF_TEST_DONE(logic_self_test_done), .ENDRV_ACT(endrv_act),
    .ENABLE_OR_INTERRUPT_OUTPUT(eoi), .REQ_SAFE(req_safe),
    .REQ_RESET(req_reset));

  esm_mcu_model #(.TICK_CYC(TCYC)) esm_mcu_model_inst (
    .clk(clk_sys), .err_line(err_in));

  // Clock of 8 ns period
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // Verdict and end of run
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // Compare one bus word
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare the three result outputs after they settle
  task automatic cmp_out(input logic e, input logic s, input logic r);
    repeat (3) @(posedge clk_sys);
    n_tests++;
    if ({eoi, req_safe, req_reset} !== {e, s, r})
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time,
               {eoi, req_safe, req_reset}, {e, s, r});
    end
  endtask

  // One single AHB-Lite transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= esm_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= a;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
    cmp32({30'h0, hresp}, {30'h0, esm_pkg::HRESP_OKAY});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp32(q & m, exp);
  endtask

  // Main sequence
  initial
  begin
    rst_n      = 1'b0;
    hsel       = 1'b0;
    haddr      = 8'h00;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    dev_state  = esm_pkg::DS_DIAG;
    logic_self_test_done = 1'b0;
    endrv_act  = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values and register access
    rd(esm_pkg::A_CTRL, 32'h0, M_ALL);
    rd(esm_pkg::A_LIM, esm_pkg::LIM_RST, M_ALL);
    rd(esm_pkg::A_THR, {24'h0, esm_pkg::THR_RST}, M_ALL);
    rd(esm_pkg::A_STAT, 32'h05, 32'h7F);
    rd(8'h10, 32'h0, M_ALL);
    wr(esm_pkg::A_LIM, 32'h0602_0602);
    wr(esm_pkg::A_THR, 32'h95);
    rd(esm_pkg::A_LIM, 32'h0602_0602, M_ALL);
    // Low pulse mode: good pulse, self test end, too long pulse
    wr(esm_pkg::A_CTRL, 32'h1);
    esm_mcu_model_inst.hold(1'b0, 4);
    esm_mcu_model_inst.hold(1'b1, 4);
    rd(esm_pkg::A_STAT, 32'h04, M_ST);
    @(posedge clk_sys);
    logic_self_test_done <= 1'b1;
    @(posedge clk_sys);
    logic_self_test_done <= 1'b0;
    rd(esm_pkg::A_STAT, 32'h05, M_ST);
    esm_mcu_model_inst.hold(1'b0, 10);
    esm_mcu_model_inst.hold(1'b1, 4);
    rd(esm_pkg::A_STAT, 32'h06, M_ST);
    // Disable, then enable with the line low: start-up timeouts
    wr(esm_pkg::A_CTRL, 32'h0);
    rd(esm_pkg::A_STAT, 32'h05, M_ST);
    esm_mcu_model_inst.hold(1'b0, 1);
    wr(esm_pkg::A_CTRL, 32'h1);
    repeat (36) @(posedge clk_sys);
    rd(esm_pkg::A_STAT, 32'h05, M_ST);
    repeat (20) @(posedge clk_sys);
    rd(esm_pkg::A_STAT, 32'h06, M_ST);
    repeat (48) @(posedge clk_sys);
    rd(esm_pkg::A_STAT, 32'h07, M_ST);
    // PWM mode: mode toggle, good pair, short and long phases
    wr(esm_pkg::A_CTRL, 32'h3);
    rd(esm_pkg::A_STAT, 32'h05, M_ST);
    esm_mcu_model_inst.good_pair(1'b1, 4);
    esm_mcu_model_inst.hold(1'b1, 4);
    rd(esm_pkg::A_STAT, 32'h04, M_ST);
    esm_mcu_model_inst.hold(1'b0, 1);
    esm_mcu_model_inst.hold(1'b1, 4);
    rd(esm_pkg::A_STAT, 32'h05, M_ST);
    esm_mcu_model_inst.hold(1'b0, 10);
    rd(esm_pkg::A_STAT, 32'h06, M_ST);
    repeat (40) @(posedge clk_sys);
    rd(esm_pkg::A_STAT, 32'h07, M_ST);
    wr(esm_pkg::A_LIM, 32'hFF02_FF02);
    // Threshold reactions with the count at seven
    cmp_out(1'b1, 1'b0, 1'b0);
    dev_state <= esm_pkg::DS_ACTIVE;
    cmp_out(1'b0, 1'b1, 1'b0);
    rd(esm_pkg::A_STAT, 32'h37, M_ST);
    dev_state <= esm_pkg::DS_DIAG;
    wr(esm_pkg::A_THR, 32'h65);
    cmp_out(1'b1, 1'b1, 1'b0);
    wr(esm_pkg::A_CTRL, 32'h7);
    cmp_out(1'b1, 1'b0, 1'b1);
    dev_state <= esm_pkg::DS_SAFE;
    wr(esm_pkg::A_THR, 32'h55);
    cmp_out(1'b1, 1'b0, 1'b0);
    wr(esm_pkg::A_STAT, 32'h30);
    rd(esm_pkg::A_STAT, 32'h07, M_ST);
    dev_state <= esm_pkg::DS_DIAG;
    rd(esm_pkg::A_STAT, 32'h05, M_ST);
    cmp_out(1'b1, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
